// ---- tb/link_rx_model.sv ----
/*
  Link receiver model: read, write and programming requests as
  one-cycle pulses. Assumes the array samples them on mclk_in.
*/
module link_rx_model (
  input wire logic mclk_in,
  output logic rd_req_out,
  output logic rd_nibble_out,
  output logic [4:0] rd_addr_out,
  output logic wr_req_out,
  output logic [3:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic prog_req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  initial begin
    {rd_req_out, rd_nibble_out, rd_addr_out, wr_req_out} = '0;
    {wr_addr_out, wr_data_out, prog_req_out} = '0;
  end
  task automatic rd(input logic nib, input logic [4:0] a);
    @(negedge mclk_in);
    rd_req_out = 1'b1;
    rd_nibble_out = nib;
    rd_addr_out = a;
    @(negedge mclk_in);
    rd_req_out = 1'b0;
    rd_addr_out = ~a;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    wr_req_out = 1'b1;
    wr_addr_out = a;
    wr_data_out = d;
    @(negedge mclk_in);
    wr_req_out = 1'b0;
    wr_data_out = ~d;
  endtask
  task automatic prog();
    @(negedge mclk_in);
    prog_req_out = 1'b1;
    @(negedge mclk_in);
    prog_req_out = 1'b0;
  endtask
endmodule

// ---- tb/tb.sv ----
/*
  Testbench for the data array: link reads, writes, programming and
  block checks. Assumes the link model drives every request.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import user_data_pkg::*;
  logic mclk_in, rst_in, rd_req, rd_nib, wr_req, prog_req, rd_valid;
  logic rd_err, wr_err, prog_pulse, f_fault, u_fault, locked;
  logic [4:0] rd_addr;
  logic [3:0] wr_addr;
  logic [7:0] wr_data, axis, fchk, uchk, status, rd_data;
  logic [31:0] trace, trim, trim_q;
  logic [63:0] user_img, prog_data;
  int error_cnt = 0, compares = 0, cyc = 0;
  link_rx_model rx (.mclk_in(mclk_in), .rd_req_out(rd_req),
    .rd_nibble_out(rd_nib), .rd_addr_out(rd_addr), .wr_req_out(wr_req),
    .wr_addr_out(wr_addr), .wr_data_out(wr_data), .prog_req_out(prog_req));
  user_data_array dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .otp_trace_word_in(trace), .otp_axis_range_in(axis),
    .otp_trim_in(trim), .otp_factory_check_in(fchk),
    .otp_user_in(user_img), .otp_user_check_in(uchk),
    .status_flags_in(status), .rd_req_in(rd_req), .rd_nibble_in(rd_nib),
    .rd_addr_in(rd_addr), .wr_req_in(wr_req), .wr_addr_in(wr_addr),
    .wr_data_in(wr_data), .prog_req_in(prog_req), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .rd_error_out(rd_err), .wr_error_out(wr_err),
    .prog_pulse_out(prog_pulse), .prog_data_out(prog_data),
    .trim_out(trim_q), .factory_fault_out(f_fault),
    .user_fault_out(u_fault), .locked_out(locked));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [63:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [71:0] d, input int n);
    logic [7:0] c;
    c = CHECK_SEED;
    for (int i = 0; i < n; i++) begin
      c = c ^ d[8*i+:8];
      for (int j = 0; j < 8; j++)
        c = c[7] ? ((c << 1) ^ CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_factory();
    // Outputs are still held in reset until the first edge after release
    repeat (2) @(negedge mclk_in);
    chk("trim", trim, trim_q);
    chk("factory fault", 0, f_fault);
    trace[31] = ~trace[31];
    repeat (2) @(negedge mclk_in);
    chk("factory fault", 1, f_fault);
    trace[31] = ~trace[31];
    repeat (2) @(negedge mclk_in);
    chk("factory fault", 0, f_fault);
    $display("factory done");
  endtask
  task automatic test_reads();
    for (int i = 0; i < 4; i++) begin
      rx.rd(1'b0, 5'(i));
      chk("trace byte", trace[8*i+:8], rd_data);
      chk("valid", 1, rd_valid);
    end
    for (int i = 0; i < 8; i++) begin
      rx.rd(1'b1, 5'(i));
      chk("trace nibble", trace[4*i+:4], rd_data);
    end
    rx.rd(1'b0, 5'h04);
    chk("axis", axis, rd_data);
    rx.rd(1'b0, 5'h0C);
    chk("status", status & 8'h7E, rd_data);
    rx.rd(1'b0, 5'h0E);
    chk("byte refused", 9'h100, {rd_err, rd_data});
    rx.rd(1'b0, 5'h10);
    chk("wide byte refused", 10'h300, {rd_valid, rd_err, rd_data});
    rx.rd(1'b1, 5'h1C);
    chk("nibble refused", 9'h100, {rd_err, rd_data});
    $display("reads done");
  endtask
  task automatic test_user();
    rx.wr(4'h7, 8'h5A);
    rx.rd(1'b0, 5'h07);
    chk("user byte", 8'h5A, rd_data);
    rx.rd(1'b1, 5'h0F);
    chk("user nibble", 8'h05, rd_data);
    rx.wr(4'h0, 8'h11);
    chk("write refused", 1, wr_err);
    user_img = 64'h80;
    uchk = crc8({8'h00, user_img}, 7) ^ 8'h01;
    rx.prog();
    chk("prog pulse", 1, prog_pulse);
    chk("prog data", 8'h5A, prog_data[23:16]);
    @(negedge mclk_in);
    chk("locked", 1, locked);
    rx.wr(4'h5, 8'h00);
    chk("locked refused", 1, wr_err);
    chk("faults", 2'b01, {f_fault, u_fault});
    rx.prog();
    chk("locked prog refused", 2'b01, {prog_pulse, wr_err});
    rx.rd(1'b0, 5'h05);
    chk("reloaded byte", 8'h80, rd_data);
    $display("user done");
  endtask
  task automatic test_reset();
    user_img[63:56] = 8'h3C;
    rst_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    chk("reset locked", 0, locked);
    // Lock comes back from the image at the first edge after release
    repeat (2) @(negedge mclk_in);
    chk("lock from image", 1, locked);
    chk("faults after reset", 2'b01, {f_fault, u_fault});
    rx.rd(1'b0, 5'h0D);
    chk("maker code", 8'h3C, rd_data);
    $display("reset done");
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Long enough for all scenarios several times over
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    rst_in = 1'b1;
    trace = 32'hA5C31E77;
    axis = 8'h25;
    trim = 32'h1234ABCD;
    fchk = crc8({trim, axis, trace}, 9);
    user_img = 64'h0;
    uchk = 8'h00;
    status = 8'hA5;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    test_factory();
    test_reads();
    test_user();
    test_reset();
    end_of_test();
  end
endmodule
bind user_data_array user_data_sva chk (.mclk_in, .rst_in,
  .otp_trace_word_in, .status_flags_in, .rd_req_in, .rd_nibble_in,
  .rd_addr_in, .wr_req_in, .wr_addr_in, .prog_req_in, .rd_valid_out,
  .rd_data_out, .rd_error_out, .wr_error_out, .prog_pulse_out,
  .locked_out);

// ---- tb/user_data_sva.sv ----
/*
  Checker for the data array: read answers, refusals and programming.
  Assumes it is bound to user_data_array and sees only its ports.
*/
module user_data_sva (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [31:0] otp_trace_word_in,
  input wire logic [7:0] status_flags_in,
  input wire logic rd_req_in,
  input wire logic rd_nibble_in,
  input wire logic [4:0] rd_addr_in,
  input wire logic wr_req_in,
  input wire logic [3:0] wr_addr_in,
  input wire logic prog_req_in,
  input wire logic rd_valid_out,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_error_out,
  input wire logic wr_error_out,
  input wire logic prog_pulse_out,
  input wire logic locked_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic rd_b, rd_n;
  // Reads in the burn cycle are still answered, but they are left out here too
  assign rd_b = rd_req_in && !rd_nibble_in && !prog_pulse_out;
  assign rd_n = rd_req_in && rd_nibble_in && !prog_pulse_out;
  chk_read_answers: assert property (rd_b || rd_n |=> rd_valid_out)
    else $error("read not answered");
  chk_no_stray: assert property (!rd_req_in |=> !rd_valid_out)
    else $error("valid without read");
  chk_unmapped_read: assert property (
    (rd_b && rd_addr_in > 5'h0D) || (rd_n && rd_addr_in > 5'h1B)
    |=> rd_error_out && rd_data_out == 8'h00)
    else $error("unmapped read not refused");
  chk_lot_byte: assert property (
    rd_b && rd_addr_in == 5'h03 ##1 $stable(otp_trace_word_in)
    |-> rd_data_out == otp_trace_word_in[31:24])
    else $error("trace byte 3 wrong");
  chk_nibble_high: assert property (
    rd_n && rd_addr_in == 5'h01 ##1 $stable(otp_trace_word_in)
    |-> rd_data_out == {4'h0, otp_trace_word_in[7:4]})
    else $error("high nibble wrong");
  chk_status_mask: assert property (
    rd_b && rd_addr_in == 5'h0C ##1 $stable(status_flags_in)
    |-> rd_data_out == (status_flags_in & 8'h7E))
    else $error("status mask wrong");
  // Writes in the burn cycle are dropped without an error pulse
  chk_write_refused: assert property (
    wr_req_in && !(wr_addr_in inside {[4'h5:4'hB], 4'hD}) && !prog_pulse_out
    |=> wr_error_out)
    else $error("bad write accepted");
  chk_locked_refused: assert property (
    (wr_req_in || prog_req_in) && locked_out && !prog_pulse_out
    |=> wr_error_out)
    else $error("locked request accepted");
  chk_prog_taken: assert property (
    prog_req_in && !wr_req_in && !locked_out && !prog_pulse_out
    |=> prog_pulse_out)
    else $error("programming not started");
  cover property (rd_n ##1 rd_valid_out);
  cover property (wr_req_in ##1 wr_error_out);
  cover property (prog_pulse_out ##2 locked_out);
endmodule

// ---- verilog/otp_block_check.sv ----
/*
  Error detection over one OTP block: a CRC-8 over N bytes compared
  with a stored check byte; the fault is registered on mclk_in.
  Assumes the block contents are stable while check_en_in is high.
*/
module otp_block_check
  import user_data_pkg::*;
#(
  parameter int N = 1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic check_en_in,
  input wire logic [8*N-1:0] data_in,
  input wire logic [7:0] stored_in,
  output logic fault_out
);

  // ----------------------------------------------------------------
  // Check logic
  // ----------------------------------------------------------------
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CHECK_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic [7:0] crc;
  logic fault_r;
  logic fault_nxt;

  always_comb begin
    crc = CHECK_SEED;
    for (int b = 0; b < N; b++) begin
      crc = crc_byte(crc, data_in[8*b +: 8]);
    end
    fault_nxt = check_en_in ? (crc != stored_in) : 1'b0;
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault_out = fault_r;

endmodule

// ---- verilog/user_data_array.sv ----
/*
  User accessible data array: factory OTP block, user OTP block and
  read-only status, read and programmed over decoded link commands.
  Assumes the link decoder gives one-cycle request pulses on mclk_in
  and that OTP contents arrive as stable, already-sampled levels.
*/
// What this block does
// - Array holds factory OTP block, user OTP block and read-only status
// - Each OTP block has its own independent error check
// - Factory trim bytes are held aside and never readable as config
// - 32-bit trace word: low 13 bits unit, upper 19 bits lot
// - Factory block check covers all four trace bytes
// - Trace word affects nothing except readout and factory check
// - User OTP locations are programmed only through link commands
// - Every readable location answers link read requests
module user_data_array
  import user_data_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [31:0] otp_trace_word_in,
  input wire logic [7:0] otp_axis_range_in,
  input wire logic [8*TRIM_BYTES-1:0] otp_trim_in,
  input wire logic [7:0] otp_factory_check_in,
  input wire logic [8*USER_BYTES-1:0] otp_user_in,
  input wire logic [7:0] otp_user_check_in,
  input wire logic [7:0] status_flags_in,
  input wire logic rd_req_in,
  input wire logic rd_nibble_in,
  input wire logic [4:0] rd_addr_in,
  input wire logic wr_req_in,
  input wire logic [3:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic prog_req_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic rd_error_out,
  output logic wr_error_out,
  output logic prog_pulse_out,
  output logic [8*USER_BYTES-1:0] prog_data_out,
  output logic [8*TRIM_BYTES-1:0] trim_out,
  output logic factory_fault_out,
  output logic user_fault_out,
  output logic locked_out
);

  // ----------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------
  function automatic logic is_user_addr(input logic [3:0] a);
    return (a >= ADDR_LINK_FORMAT_CONFIG && a <= ADDR_USER_DAY_DATA) ||
           (a == ADDR_MAKER_CODE);
  endfunction

  function automatic int user_index(input logic [3:0] a);
    return (a == ADDR_MAKER_CODE) ? USER_BYTES - 1 :
           int'(a) - int'(ADDR_LINK_FORMAT_CONFIG);
  endfunction

  // ----------------------------------------------------------------
  // Factory block and its check
  // ----------------------------------------------------------------
  logic [8*FACTORY_BYTES-1:0] factory_bytes;
  logic [8*(FACTORY_BYTES+TRIM_BYTES)-1:0] factory_checked;
  logic [TRACE_UNIT_W-1:0] trace_unit;
  logic [TRACE_LOT_W-1:0] trace_lot;
  logic factory_fault;
  logic user_fault;

  assign trace_unit = otp_trace_word_in[TRACE_UNIT_W-1:0];
  assign trace_lot = otp_trace_word_in[TRACE_LOT_LSB +: TRACE_LOT_W];
  // Trace word drives only readout and the check below
  assign factory_bytes = {otp_axis_range_in, trace_lot, trace_unit};
  assign factory_checked = {otp_trim_in, factory_bytes};

  otp_block_check #(.N(FACTORY_BYTES + TRIM_BYTES)) u_factory_check (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .check_en_in(1'b1),
    .data_in(factory_checked),
    .stored_in(otp_factory_check_in),
    .fault_out(factory_fault)
  );

  // ----------------------------------------------------------------
  // User shadow, programming and lock
  // ----------------------------------------------------------------
  nvm_state_t state_r, state_nxt;
  logic [8*USER_BYTES-1:0] shadow_r, shadow_nxt;
  logic loaded_r, loaded_nxt;
  logic locked_r, locked_nxt;
  logic wr_error_r, wr_error_nxt;
  logic prog_pulse_r, prog_pulse_nxt;
  logic [8*USER_BYTES-1:0] prog_data_r, prog_data_nxt;

  // Check runs only once locked; before that the array is still open
  otp_block_check #(.N(USER_BYTES - 1)) u_user_check (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .check_en_in(locked_r),
    .data_in(otp_user_in[8*(USER_BYTES-1)-1:0]),
    .stored_in(otp_user_check_in),
    .fault_out(user_fault)
  );

  always_comb begin
    state_nxt = state_r;
    shadow_nxt = shadow_r;
    loaded_nxt = 1'b1;
    locked_nxt = locked_r;
    wr_error_nxt = 1'b0;
    prog_pulse_nxt = 1'b0;
    prog_data_nxt = prog_data_r;
    case (state_r)
      NVM_IDLE: begin
        if (!loaded_r) begin
          shadow_nxt = otp_user_in;
          locked_nxt = otp_user_in[LOCK_U_BIT];
        end else if (wr_req_in) begin
          // Only the link writes the shadow; otherwise it loads from the OTP image
          if (is_user_addr(wr_addr_in) && !locked_r) begin
            shadow_nxt[8*user_index(wr_addr_in) +: 8] = wr_data_in;
          end else begin
            wr_error_nxt = 1'b1;
          end
        end else if (prog_req_in) begin
          if (locked_r) begin
            wr_error_nxt = 1'b1;
          end else begin
            prog_pulse_nxt = 1'b1;
            prog_data_nxt = shadow_r;
            state_nxt = NVM_BURN;
          end
        end
      end
      NVM_BURN: begin
        // Readout after burning; lock takes effect from the OTP image
        shadow_nxt = otp_user_in;
        locked_nxt = otp_user_in[LOCK_U_BIT];
        state_nxt = NVM_IDLE;
      end
      default: begin
        state_nxt = NVM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= NVM_IDLE;
      shadow_r <= {USER_BYTES{USER_RESET}};
      loaded_r <= 1'b0;
      locked_r <= 1'b0;
      wr_error_r <= 1'b0;
      prog_pulse_r <= 1'b0;
      prog_data_r <= {USER_BYTES{USER_RESET}};
    end else begin
      state_r <= state_nxt;
      shadow_r <= shadow_nxt;
      loaded_r <= loaded_nxt;
      locked_r <= locked_nxt;
      wr_error_r <= wr_error_nxt;
      prog_pulse_r <= prog_pulse_nxt;
      prog_data_r <= prog_data_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link read path
  // ----------------------------------------------------------------
  logic rd_valid_r, rd_valid_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic rd_error_r, rd_error_nxt;
  logic [3:0] byte_addr;
  logic [7:0] byte_val;

  // Trim bytes have no address, so they can never be read back
  always_comb begin
    byte_addr = rd_nibble_in ? rd_addr_in[4:1] : rd_addr_in[3:0];
    byte_val = 8'h00;
    if (byte_addr <= ADDR_SN3) begin
      byte_val = otp_trace_word_in[8*byte_addr[1:0] +: 8];
    end else if (byte_addr == ADDR_FACTORY_AXIS_RANGE) begin
      byte_val = otp_axis_range_in;
    end else if (byte_addr == ADDR_STATUS_FLAGS) begin
      byte_val = status_flags_in & STATUS_FIXED_MASK;
    end else if (is_user_addr(byte_addr)) begin
      byte_val = shadow_r[8*user_index(byte_addr) +: 8];
    end
    rd_valid_nxt = rd_req_in;
    rd_data_nxt = rd_data_r;
    rd_error_nxt = 1'b0;
    if (rd_req_in) begin
      if (!rd_nibble_in && rd_addr_in[4]) begin
        rd_error_nxt = 1'b1;
        rd_data_nxt = 8'h00;
      end else if (byte_addr > ADDR_LAST) begin
        rd_error_nxt = 1'b1;
        rd_data_nxt = 8'h00;
      end else if (rd_nibble_in) begin
        rd_data_nxt = {4'h0, rd_addr_in[0] ? byte_val[7:4] :
                                            byte_val[3:0]};
      end else begin
        rd_data_nxt = byte_val;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      rd_error_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_valid_nxt;
      rd_data_r <= rd_data_nxt;
      rd_error_r <= rd_error_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [8*TRIM_BYTES-1:0] trim_r;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      trim_r <= '0;
    end else begin
      trim_r <= otp_trim_in;
    end
  end

  assign rd_valid_out = rd_valid_r;
  assign rd_data_out = rd_data_r;
  assign rd_error_out = rd_error_r;
  assign wr_error_out = wr_error_r;
  assign prog_pulse_out = prog_pulse_r;
  assign prog_data_out = prog_data_r;
  assign trim_out = trim_r;
  assign factory_fault_out = factory_fault;
  assign user_fault_out = user_fault;
  assign locked_out = locked_r;

endmodule

// ---- verilog/user_data_pkg.sv ----
/*
  Constants for the user accessible data array: byte addresses,
  field positions, reset values and the check polynomial.
  Assumes nothing of its surroundings.
*/
package user_data_pkg;

  // ----------------------------------------------------------------
  // Byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SN0 = 4'h0;
  localparam logic [3:0] ADDR_SN3 = 4'h3;
  localparam logic [3:0] ADDR_FACTORY_AXIS_RANGE = 4'h4;
  localparam logic [3:0] ADDR_LINK_FORMAT_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_FILTER_MODE_SLOT_HIGH = 4'h6;
  localparam logic [3:0] ADDR_SLOT_A_LOW = 4'h7;
  localparam logic [3:0] ADDR_SLOT_B_LOW = 4'h8;
  localparam logic [3:0] ADDR_INIT_ASYNC_USER_REVISION = 4'h9;
  localparam logic [3:0] ADDR_USER_MONTH_YEAR = 4'hA;
  localparam logic [3:0] ADDR_USER_DAY_DATA = 4'hB;
  localparam logic [3:0] ADDR_STATUS_FLAGS = 4'hC;
  localparam logic [3:0] ADDR_MAKER_CODE = 4'hD;
  localparam logic [3:0] ADDR_LAST = 4'hD;

  // ----------------------------------------------------------------
  // Fields and sizes
  // ----------------------------------------------------------------
  localparam int TRACE_UNIT_W = 13;
  localparam int TRACE_LOT_LSB = 13;
  localparam int TRACE_LOT_W = 19;
  localparam int LOCK_U_BIT = 7;
  localparam int USER_BYTES = 8;
  localparam int FACTORY_BYTES = 5;
  localparam int TRIM_BYTES = 4;
  localparam logic [7:0] STATUS_FIXED_MASK = 8'h7E;
  localparam logic [7:0] USER_RESET = 8'h00;
  localparam logic [7:0] CHECK_POLY = 8'h07;
  localparam logic [7:0] CHECK_SEED = 8'hFF;

  // ----------------------------------------------------------------
  // Programming states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    NVM_IDLE = 2'b01,
    NVM_BURN = 2'b10
  } nvm_state_t;

endpackage
